// ==== core/cses_pkg.sv ====
// Package for the command structure endian swap block.
// Assumes a single 250 MHz clock and 32-bit double-word paths.
package cses_pkg;

    // ------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------
    localparam int CSES_DW = 32;
    localparam logic [4:0] CSES_CTL_BSWAP_BIT = 5'h00;
    localparam logic [4:0] CSES_CTL_WSWAP_BIT = 5'h01;

    // ------------------------------------------------------------
    // Parameter block double-word offsets (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] CSES_OFF_CMD_ID = 8'h00;
    localparam logic [7:0] CSES_OFF_FLAGS = 8'h04;
    localparam logic [7:0] CSES_OFF_HOST_ADDR = 8'h08;
    localparam logic [7:0] CSES_OFF_XFER_CNT = 8'h0C;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic CSES_SWAP_RST = 1'b0;
    localparam logic [31:0] CSES_WORD_RST = 32'h0000_0000;

    // Swap selection carried as one unit
    typedef struct packed {
        logic word_swap;
        logic byte_swap;
    } cses_swap_s;

    // A double-word seen on the bus, with its block offset
    typedef struct packed {
        logic [7:0] off;
        logic is_cmd;
        logic [31:0] data;
    } cses_beat_s;

    // Fields decoded from the parameter block
    typedef struct packed {
        logic [31:0] cmd_id;
        logic [7:0] target_id;
        logic [7:0] addr_mod;
        logic [7:0] flags1;
        logic [7:0] flags2;
        logic [31:0] host_addr;
        logic [31:0] xfer_cnt;
    } cses_pblk_s;

endpackage

// ==== core/cses_swap.sv ====
// Endian adaptation of command structure double-words.
// Assumes beats arrive synchronous to clk_sys, one per valid cycle,
// and the first command port word arrives before the block.
`timescale 1ns/10ps
`default_nettype none

// Function
// RQ1 - Default order is big-endian, no swap
// RQ2 - Independent byte and word swap bits
// RQ3 - Swap bits taken from first port word
// RQ4 - Reorder per 32-bit double-word only
// RQ5 - Both swaps serve little-endian hosts natively
// RQ6 - Little-endian maps lane 0 to lane 3
// RQ7 - Endian convention: LSB high vs low address
// RQ8 - Host address from offset 08H
// RQ9 - Transfer count from offset 0CH
// RQ10 - Command id at 00H, flags at 04H
// RQ11 - User data passes without swapping
// RQ12 - Byte swap in halves, word swap halves
module cses_swap
    import cses_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic port_wr,
    input wire logic port_first,
    input wire logic [31:0] port_data,
    input wire logic in_valid,
    input wire cses_beat_s in_beat,
    output logic out_valid,
    output logic [31:0] out_data,
    output var cses_swap_s swap_sel,
    output var cses_pblk_s pblk,
    output logic pblk_done
);

    // ----------------------------------------------------------------
    // Swap selection
    // ----------------------------------------------------------------
    cses_swap_s swap_r;
    logic [31:0] sw_word;
    logic [31:0] out_data_r;
    logic out_valid_r;
    cses_pblk_s pblk_r;
    logic pblk_done_r;

    // RQ3 swap from first word
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            swap_r <= '{word_swap: CSES_SWAP_RST, byte_swap: CSES_SWAP_RST};
        end else if (port_wr && port_first) begin
            // RQ2 two independent bits
            swap_r.byte_swap <= port_data[CSES_CTL_BSWAP_BIT];
            swap_r.word_swap <= port_data[CSES_CTL_WSWAP_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Lane reordering
    // ----------------------------------------------------------------
    // RQ12 byte then word swap
    // RQ4 whole double-word unit
    always_comb begin
        // RQ1 RQ7 default order kept
        sw_word = in_beat.data;
        // RQ5 RQ6 both swaps reverse lanes
        if (swap_r.byte_swap) begin
            sw_word = {sw_word[23:16], sw_word[31:24], sw_word[7:0], sw_word[15:8]};
        end
        if (swap_r.word_swap) begin
            sw_word = {sw_word[15:0], sw_word[31:16]};
        end
        // RQ11 user data untouched
        if (!in_beat.is_cmd) begin
            sw_word = in_beat.data;
        end
    end

    // Registered output, one cycle latency
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            out_valid_r <= 1'b0;
            out_data_r <= CSES_WORD_RST;
        end else begin
            out_valid_r <= in_valid;
            if (in_valid) begin
                out_data_r <= sw_word;
            end
        end
    end

    // ----------------------------------------------------------------
    // Parameter block field capture
    // ----------------------------------------------------------------
    // Fields hold big-endian view after the swap, so the decode is fixed
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pblk_r <= '0;
            pblk_done_r <= 1'b0;
        end else begin
            pblk_done_r <= 1'b0;
            if (in_valid && in_beat.is_cmd) begin
                unique case (in_beat.off)
                    // RQ10 command identifier
                    CSES_OFF_CMD_ID: begin
                        pblk_r.cmd_id <= sw_word;
                    end
                    // RQ10 flags lanes, lane 0 most significant
                    CSES_OFF_FLAGS: begin
                        pblk_r.flags2 <= sw_word[31:24];
                        pblk_r.flags1 <= sw_word[23:16];
                        pblk_r.addr_mod <= sw_word[15:8];
                        pblk_r.target_id <= sw_word[7:0];
                    end
                    // RQ8 host address
                    CSES_OFF_HOST_ADDR: begin
                        pblk_r.host_addr <= sw_word;
                    end
                    // RQ9 transfer count
                    CSES_OFF_XFER_CNT: begin
                        pblk_r.xfer_cnt <= sw_word;
                        pblk_done_r <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    assign out_valid = out_valid_r;
    assign out_data = out_data_r;
    assign swap_sel = swap_r;
    assign pblk = pblk_r;
    assign pblk_done = pblk_done_r;

    // ----------------------------------------------------------------
    // Reference lane map for the checks
    // ----------------------------------------------------------------
    // Built as a lane index map, not a copy of the swap chain, so a
    // slip in the reorder above cannot hide in its own check
    logic [1:0] lane_xor;
    logic [31:0] ref_word;

    // Byte swap flips index bit 0, word swap bit 1; user data maps flat
    assign lane_xor = in_beat.is_cmd ? {swap_r.word_swap, swap_r.byte_swap} : 2'b00;

    // RQ12 one lane per loop pass
    for (genvar gi = 0; gi < 4; gi++) begin : g_ref_lane
        assign ref_word[31 - 8 * gi -: 8] = in_beat.data[31 - 8 * (gi ^ lane_xor) -: 8];
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_default_big_endian: assert property ( // RQ1
        in_valid && in_beat.is_cmd && !swap_r.byte_swap && !swap_r.word_swap
        |=> out_data == $past(in_beat.data))
        else $error("default order altered");

    a_full_reverse: assert property ( // RQ6
        in_valid && in_beat.is_cmd && swap_r.byte_swap && swap_r.word_swap
        |=> out_data[7:0] == $past(in_beat.data[31:24]) && out_data[31:24] == $past(in_beat.data[7:0]))
        else $error("lane 0 not moved to lane 3");

    a_le_host_native: assert property ( // RQ5
        in_valid && in_beat.is_cmd && swap_r.byte_swap && swap_r.word_swap
        |=> out_data == {<<8{$past(in_beat.data)}})
        else $error("full reversal wrong");

    a_byte_only: assert property ( // RQ12
        in_valid && in_beat.is_cmd && swap_r.byte_swap && !swap_r.word_swap
        |=> out_data == {$past(in_beat.data[23:16]), $past(in_beat.data[31:24]),
                         $past(in_beat.data[7:0]), $past(in_beat.data[15:8])})
        else $error("byte swap wrong");

    a_word_only: assert property ( // RQ2
        in_valid && in_beat.is_cmd && !swap_r.byte_swap && swap_r.word_swap
        |=> out_data == {$past(in_beat.data[15:0]), $past(in_beat.data[31:16])})
        else $error("word swap wrong");

    a_swap_capture: assert property ( // RQ3
        port_wr && port_first |=> swap_sel.byte_swap == $past(port_data[0])
        && swap_sel.word_swap == $past(port_data[1]))
        else $error("swap bits not taken");

    a_swap_hold: assert property ( // RQ3
        !(port_wr && port_first) |=> $stable(swap_sel))
        else $error("swap changed without first word");

    a_data_passthru: assert property ( // RQ11
        in_valid && !in_beat.is_cmd |=> out_data == $past(in_beat.data))
        else $error("user data swapped");

    a_host_addr: assert property ( // RQ8
        in_valid && in_beat.is_cmd && in_beat.off == CSES_OFF_HOST_ADDR
        |=> pblk.host_addr == $past(sw_word))
        else $error("host address not captured");

    a_xfer_cnt: assert property ( // RQ9
        in_valid && in_beat.is_cmd && in_beat.off == CSES_OFF_XFER_CNT
        |=> pblk.xfer_cnt == $past(sw_word) && pblk_done)
        else $error("transfer count not captured");

    a_flags_lanes: assert property ( // RQ10
        in_valid && in_beat.is_cmd && in_beat.off == CSES_OFF_FLAGS
        |=> pblk.flags2 == $past(sw_word[31:24]) && pblk.target_id == $past(sw_word[7:0]))
        else $error("flags lanes wrong");

    a_valid_follow: assert property ( // RQ4
        in_valid |=> out_valid)
        else $error("beat lost");

    // Whole beat against the independent lane map
    a_lane_map: assert property ( // RQ4
        in_valid |=> out_data == $past(ref_word))
        else $error("lane map differs");

    // Middle lanes also cross on a full reversal
    a_mid_lanes: assert property ( // RQ6
        in_valid && in_beat.is_cmd && swap_r.byte_swap && swap_r.word_swap
        |=> out_data[15:8] == $past(in_beat.data[23:16]) && out_data[23:16] == $past(in_beat.data[15:8]))
        else $error("middle lanes not reversed");

    // Output valid lasts one cycle per beat
    a_valid_drop: assert property ( // RQ4
        !in_valid |=> !out_valid)
        else $error("output valid without beat");

    // Output word holds between beats
    a_out_hold: assert property ( // RQ4
        !in_valid |=> $stable(out_data))
        else $error("output word moved between beats");

    // Command identifier against the lane map
    a_cmd_id: assert property ( // RQ10
        in_valid && in_beat.is_cmd && in_beat.off == CSES_OFF_CMD_ID
        |=> pblk.cmd_id == $past(ref_word))
        else $error("command id not captured");

    // Middle flag lanes against the lane map
    a_flags_mid: assert property ( // RQ10
        in_valid && in_beat.is_cmd && in_beat.off == CSES_OFF_FLAGS
        |=> pblk.flags1 == $past(ref_word[23:16]) && pblk.addr_mod == $past(ref_word[15:8]))
        else $error("middle flag lanes wrong");

    // Default order puts lane 0 into the second flags byte
    a_be_flags: assert property ( // RQ1
        in_valid && in_beat.is_cmd && in_beat.off == CSES_OFF_FLAGS && !swap_r.byte_swap && !swap_r.word_swap
        |=> pblk.flags2 == $past(in_beat.data[31:24]) && pblk.target_id == $past(in_beat.data[7:0]))
        else $error("default flag lanes wrong");

    // Host address against the lane map
    a_addr_ref: assert property ( // RQ8
        in_valid && in_beat.is_cmd && in_beat.off == CSES_OFF_HOST_ADDR
        |=> pblk.host_addr == $past(ref_word))
        else $error("host address lanes wrong");

    // Little-endian count arrives fully reversed
    a_le_count: assert property ( // RQ5
        in_valid && in_beat.is_cmd && in_beat.off == CSES_OFF_XFER_CNT && swap_r.byte_swap && swap_r.word_swap
        |=> pblk.xfer_cnt == {<<8{$past(in_beat.data)}})
        else $error("little-endian count wrong");

    // Default order leaves the count untouched
    a_be_count: assert property ( // RQ1
        in_valid && in_beat.is_cmd && in_beat.off == CSES_OFF_XFER_CNT && !swap_r.byte_swap && !swap_r.word_swap
        |=> pblk.xfer_cnt == $past(in_beat.data))
        else $error("default count reordered");

    // Word swap alone moves the count halves
    a_word_count: assert property ( // RQ2
        in_valid && in_beat.is_cmd && in_beat.off == CSES_OFF_XFER_CNT && !swap_r.byte_swap && swap_r.word_swap
        |=> pblk.xfer_cnt == {$past(in_beat.data[15:0]), $past(in_beat.data[31:16])})
        else $error("word swapped count wrong");

    // Done pulses only after a count beat; a repeated 0CH pulses again
    a_done_pulse: assert property ( // RQ9
        pblk_done == $past(in_valid && in_beat.is_cmd && in_beat.off == CSES_OFF_XFER_CNT))
        else $error("done pulse misplaced");

    // Nothing captures without a command beat
    a_pblk_hold: assert property ( // RQ11
        !(in_valid && in_beat.is_cmd) |=> $stable(pblk))
        else $error("block fields moved by user data");

    // Non-first port words never touch the selection
    a_first_only: assert property ( // RQ3
        port_wr && !port_first |=> $stable(swap_sel))
        else $error("swap taken from later word");

    c_le_block: cover property (swap_r.byte_swap && swap_r.word_swap && pblk_done);
    c_be_block: cover property (!swap_r.byte_swap && !swap_r.word_swap && pblk_done);
    c_user_data: cover property (in_valid && !in_beat.is_cmd && swap_r.byte_swap);
    // Single-swap modes on a command beat
    c_byte_only: cover property (in_valid && in_beat.is_cmd && swap_r.byte_swap && !swap_r.word_swap);
    c_word_only: cover property (in_valid && in_beat.is_cmd && !swap_r.byte_swap && swap_r.word_swap);

endmodule

`default_nettype wire

// ==== sim/cses_host.sv ====
// Host processor model: writes command port words and structure beats.
// Assumes the bench calls one task at a time, from a single process.
`timescale 1ns/10ps
`default_nettype none
module cses_host
    import cses_pkg::*;
(
    input wire logic clk_sys,
    output var logic port_wr,
    output var logic port_first,
    output var logic [31:0] port_data,
    output var logic in_valid,
    output var cses_beat_s in_beat
);
    // Bus idle from time zero
    initial begin
        port_wr = 1'b0;
        port_first = 1'b0;
        port_data = 32'h0;
        in_valid = 1'b0;
        in_beat = '0;
    end

    task automatic put_port(input logic [31:0] d, input logic first);
        @(posedge clk_sys);
        #1;
        port_wr = 1'b1;
        port_first = first;
        port_data = d;
        @(posedge clk_sys);
        #1;
        port_wr = 1'b0;
        // Released word inverted, so no stale value reads as valid
        port_data = ~d;
    endtask

    task automatic put_beat(input logic [7:0] off, input logic cmd, input logic [31:0] d);
        @(posedge clk_sys);
        #1;
        in_valid = 1'b1;
        in_beat = '{off: off, is_cmd: cmd, data: d};
        @(posedge clk_sys);
        #1;
        in_valid = 1'b0;
        in_beat.data = ~d;
    endtask
endmodule
`default_nettype wire

// ==== sim/cses_swap_tb_top.sv ====
// Bench for the endian swap block, driven through the host model.
// Assumes answers settle one cycle after each request is taken.
`timescale 1ns/10ps
`default_nettype none
module cses_swap_tb_top;
    import cses_pkg::*;
    logic clk_sys, arst_n, port_wr, port_first, in_valid, out_valid, pblk_done;
    logic [31:0] port_data, out_data;
    cses_beat_s in_beat;
    cses_swap_s swap_sel;
    cses_pblk_s pblk;
    int error_cnt = 0;
    int samples_checked = 0;

    cses_host i_host (.clk_sys(clk_sys), .port_wr(port_wr), .port_first(port_first),
        .port_data(port_data), .in_valid(in_valid), .in_beat(in_beat));
    cses_swap i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .port_wr(port_wr), .port_first(port_first),
        .port_data(port_data), .in_valid(in_valid), .in_beat(in_beat), .out_valid(out_valid),
        .out_data(out_data), .swap_sel(swap_sel), .pblk(pblk), .pblk_done(pblk_done));

    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Whole run is under 100 cycles; 2000 leaves ample margin
    initial begin
        #8000;
        error_cnt++;
        complete_run();
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Reference reorder: byte swap in halves, then halves exchanged
    function automatic logic [31:0] swp(input logic [31:0] d, input logic [1:0] m);
        logic [31:0] b;
        b = m[0] ? {d[23:16], d[31:24], d[7:0], d[15:8]} : d;
        return m[1] ? {b[15:0], b[31:16]} : b;
    endfunction

    // Default order: no swap, command id at 00H
    task automatic t_default();
        i_host.put_port(32'h0, 1'b1);
        i_host.put_beat(8'h00, 1'b1, 32'h0403_0201);
        chk("out_data", 32'h0403_0201, out_data);
        chk("cmd_id", 32'h0403_0201, pblk.cmd_id);
    endtask

    // Every swap mode applied to the transfer count
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            i_host.put_port({30'h0, m[1:0]}, 1'b1);
            chk("swap_sel", {30'h0, m[1:0]}, {30'h0, swap_sel});
            i_host.put_beat(8'h0C, 1'b1, swp(32'h0001_0280, m[1:0]));
            chk("out_valid", 32'h1, {31'h0, out_valid});
            chk("out_data", 32'h0001_0280, out_data);
            chk("xfer_cnt", 32'h0001_0280, pblk.xfer_cnt);
            chk("pblk_done", 32'h1, {31'h0, pblk_done});
        end
    endtask

    // Little-endian host block fields, lanes reversed
    task automatic t_fields();
        i_host.put_beat(8'h04, 1'b1, 32'h023E_8601);
        chk("out_data", 32'h0186_3E02, out_data);
        chk("flags", {8'h01, 8'h86, 8'h3E, 8'h02}, {pblk.flags2, pblk.flags1, pblk.addr_mod, pblk.target_id});
        i_host.put_beat(8'h08, 1'b1, 32'h2093_5A00);
        chk("host_addr", 32'h005A_9320, pblk.host_addr);
    endtask

    // Non-first port word ignored; user data never reordered
    task automatic t_refuse();
        i_host.put_port(32'h0, 1'b0);
        chk("swap_sel", 32'h3, {30'h0, swap_sel});
        i_host.put_beat(8'h0C, 1'b0, 32'h1122_3344);
        chk("user_data", 32'h1122_3344, out_data);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence; mode 3 is left selected for the later tasks
    initial begin
        arst_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        t_default();
        t_modes();
        t_fields();
        t_refuse();
        complete_run();
    end
endmodule
`default_nettype wire
